// file: sim/dlwd_host.sv
// ahb-lite host model that drives the watchdog register slave
`timescale 1ns/100ps
module dlwd_host (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	output logic [31:0]      rd_data,
	output logic             rd_tog
);
	// idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rd_data = 32'h0;
		rd_tog = 1'b0;
	end
	// bounded wait for hready at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 50) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 50) begin
			tb.failures++;
			tb.final_report();
		end
	endtask
	// single word transfer, address phase then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= w ? d : 32'h0;
		wait_ready();
		if (!w) begin
			rd_data <= hrdata;
			rd_tog <= ~rd_tog;
		end
	endtask
endmodule

// file: sim/tb.sv
// self-checking testbench for the dual level watchdog
`timescale 1ns/100ps
module tb;
	localparam int MS  = 20;
	localparam int TMO = 100;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        watchdog_disable_pin;
	logic        wd_reset_out;
	logic        algorithmic_lock_flag;
	logic        window_error;
	logic [31:0] rd_data;
	logic        rd_tog;
	logic [31:0] m;
	logic [7:0]  k;
	logic        rst_q;
	int          failures;
	int          compares;
	int          werr_cnt;
	int          wrst_cnt;
	int          seed;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	string       nam_q[$];
	dlwd_top #(.STEP_SLOW_CYC(16), .MS_CYC(MS), .INIT_CYC(200), .WD2_TMO_CYC(TMO)) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.watchdog_disable_pin(watchdog_disable_pin), .wd_reset_out(wd_reset_out),
		.algorithmic_lock_flag(algorithmic_lock_flag), .window_error(window_error));
	dlwd_host host (
		.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.rd_data(rd_data), .rd_tog(rd_tog));
	// 200 mhz clock
	always #2.5 hclk = ~hclk;
	// count error pulses and reset assertions
	always @(posedge hclk) begin
		if (window_error === 1'b1) werr_cnt++;
		if (wd_reset_out === 1'b1 && rst_q !== 1'b1) wrst_cnt++;
		rst_q = wd_reset_out;
	end
	// compare each read result with the oldest note
	always @(rd_tog) begin
		if (exp_q.size() > 0) begin
			m = msk_q.pop_front();
			check(nam_q.pop_front(), rd_data & m, exp_q.pop_front() & m);
		end
	end
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rd(string nm, logic [7:0] a, logic [31:0] msk, logic [31:0] e);
		nam_q.push_back(nm);
		msk_q.push_back(msk);
		exp_q.push_back(e);
		host.xfer(1'b0, a, 32'h0);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		host.xfer(1'b1, a, d);
	endtask
	// refresh code pair, random upper bits
	task automatic pair(logic [1:0] c1, logic [1:0] c2);
		wr(dlwd_pkg::REG_REFRESH, (32'($random(seed)) & 32'hFFFF_FFFC) | {30'h0, c1});
		wr(dlwd_pkg::REG_REFRESH, (32'($random(seed)) & 32'hFFFF_FFFC) | {30'h0, c2});
	endtask
	// read seed and previous key, answer with the next key
	task automatic feed(input logic [7:0] pk, output logic [7:0] nk);
		rd("prev key", dlwd_pkg::REG_SEED, 32'h0000_FF00, {16'h0, pk, 8'h0});
		nk = (hrdata[7:0] ^ pk) + 8'h01;
		wr(dlwd_pkg::REG_KEY, {24'h0, nk});
	endtask
	task automatic note(string s);
		$display("test %s done", s);
	endtask
	task automatic final_report();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		seed = 32'h58D7;
		failures = 0;
		compares = 0;
		werr_cnt = 0;
		wrst_cnt = 0;
		hclk = 1'b0;
		hresetn = 1'b0;
		watchdog_disable_pin = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd("config", dlwd_pkg::REG_CONFIG, 32'hFFFF_FFFF, 32'h0080_4000);
		rd("status", dlwd_pkg::REG_STATUS, 32'h03FF_0704, 32'h0001_0104);
		rd("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
		wr(dlwd_pkg::REG_CONFIG, 32'h0004_0401);
		rd("config", dlwd_pkg::REG_CONFIG, 32'hFFFF_FFFF, 32'h0004_0401);
		wr(dlwd_pkg::REG_COMMAND, 32'h1);
		wr(dlwd_pkg::REG_CONFIG, 32'h0);
		rd("frozen", dlwd_pkg::REG_CONFIG, 32'hFFFF_FFFF, 32'h0004_0401);
		note("config");
		pair(dlwd_pkg::CODE_A, dlwd_pkg::CODE_B);
		rd("win run", dlwd_pkg::REG_STATUS, 32'h700, 32'h200);
		pair(2'h0, 2'h3);
		pair(2'h3, 2'h0);
		repeat (2) @(posedge hclk);
		check("wrong code", werr_cnt, 0);
		pair(dlwd_pkg::CODE_A, dlwd_pkg::CODE_B);
		repeat (3) @(posedge hclk);
		check("early", werr_cnt, 1);
		check("rst out", wd_reset_out, 1);
		rd("win rst", dlwd_pkg::REG_STATUS, 32'h700, 32'h400);
		repeat (MS + 5) @(posedge hclk);
		rd("win init", dlwd_pkg::REG_STATUS, 32'h700, 32'h100);
		repeat (210) @(posedge hclk);
		check("allowance", werr_cnt, 2);
		repeat (MS + 5) @(posedge hclk);
		wr(dlwd_pkg::REG_COMMAND, 32'h2);
		repeat (250) @(posedge hclk);
		check("to disable", werr_cnt, 2);
		note("window init");
		pair(dlwd_pkg::CODE_B, dlwd_pkg::CODE_A);
		repeat (80) @(posedge hclk);
		pair(dlwd_pkg::CODE_B, dlwd_pkg::CODE_A);
		rd("timer", dlwd_pkg::REG_REFRESH, 32'hF8, 32'h0);
		repeat (75) @(posedge hclk);
		pair(dlwd_pkg::CODE_A, dlwd_pkg::CODE_B);
		repeat (2) @(posedge hclk);
		check("in window", werr_cnt, 2);
		repeat (200) @(posedge hclk);
		check("late", werr_cnt, 3);
		note("window run");
		wr(dlwd_pkg::REG_KEY, 32'h5A);
		rd("seedinit", dlwd_pkg::REG_STATUS, 32'h03FF_0000, 32'h0004_0000);
		feed(8'h5A, k);
		rd("alg run", dlwd_pkg::REG_STATUS, 32'h03FF_0000, 32'h0008_0000);
		feed(k, k);
		rd("early key", dlwd_pkg::REG_STATUS, 32'h03FF_0000, 32'h0008_0000);
		repeat (TMO + 10) @(posedge hclk);
		rd("qual", dlwd_pkg::REG_STATUS, 32'hF3FF_0000, 32'h1020_0000);
		repeat (2 * TMO + MS + 20) @(posedge hclk);
		rd("lock", dlwd_pkg::REG_STATUS, 32'h03FF_0004, 32'h0040_0004);
		check("alg rst", wrst_cnt, 4);
		wr(dlwd_pkg::REG_COMMAND, 32'h20);
		rd("fsm rst", dlwd_pkg::REG_STATUS, 32'hF3FF_0026, 32'h0001_0000);
		check("lock pin", algorithmic_lock_flag, 0);
		note("alg lock");
		wr(dlwd_pkg::REG_COMMAND, 32'h2);
		wr(dlwd_pkg::REG_KEY, 32'h5A);
		feed(8'h5A, k);
		wr(dlwd_pkg::REG_COMMAND, 32'h4);
		rd("test", dlwd_pkg::REG_STATUS, 32'h03FF_0000, 32'h0010_0000);
		repeat (TMO + MS + 20) @(posedge hclk);
		rd("test end", dlwd_pkg::REG_STATUS, 32'h03FF_0006, 32'h0008_0002);
		check("test rst", wrst_cnt, 4);
		check("test lock", algorithmic_lock_flag, 0);
		wr(dlwd_pkg::REG_COMMAND, 32'h40);
		rd("ssm rst", dlwd_pkg::REG_STATUS, 32'h03FF_0000, 32'h0001_0000);
		note("alg test");
		watchdog_disable_pin <= 1'b1;
		wr(dlwd_pkg::REG_COMMAND, 32'h20);
		wr(dlwd_pkg::REG_COMMAND, 32'h8);
		repeat (300) @(posedge hclk);
		rd("override", dlwd_pkg::REG_STATUS, 32'h03FF_0008, 32'h0002_0008);
		check("pin held", werr_cnt, 3);
		check("hresp", hresp, 0);
		note("override");
		final_report();
	end
endmodule

// file: verilog/dlwd_pkg.sv
// constants for the dual level watchdog
// How it works
// - fast mode spans 2 ms, 8 us steps
// - slow mode spans 16.3 ms, 64 us steps
// - config writes only in init state
// - diag state starts window supervision, freezes config
// - timeout disable allows staying initial forever
// - correct refresh outside window raises error
// - wrong refresh code never raises error
// - correct in-window refresh restarts the window
// - codes A and B either order clear timer
// - refresh register reads window timer value
// - algorithmic refresh accepted any time before expiry
// - init at startup and non-stop safing reset
// - default key in init starts seed init
// - test state: no reset, lock not raised, latch only
// - qualify state counts errors before acting
// - retry counter increments per qualified error
// - retries exhausted leads to lock state
// - stopping state lasts 1 ms then leaves
// - stop state blocks key recovery
// - algorithmic reset state lasts 1 ms
// - fsm reset forces init, clears signals
// - override state disables algorithmic supervision
// - window error enters 1 ms reset state
// - eight bit key is seed xor previous plus one
// - disable pin clears timers, blocks faults
package dlwd_pkg;
	localparam int          CLK_PERIOD_PS  = 5000;
	localparam int          T_STEP_FAST_PS = 8000000;
	localparam int          T_STEP_SLOW_PS = 64000000;
	localparam int          T_SPAN_FAST_US = 2000;
	localparam int          T_SPAN_SLOW_US = 16300;
	localparam int          T_STATE_MS     = 1;
	localparam int          T_INIT_MS      = 500;
	localparam int          STEP_FAST_CYC  = T_STEP_FAST_PS / CLK_PERIOD_PS;
	localparam int          STEP_SLOW_CYC  = T_STEP_SLOW_PS / CLK_PERIOD_PS;
	localparam int          CYC_PER_MS     = 1000000000 / CLK_PERIOD_PS;
	// scaled to nanoseconds so the products stay inside a 32-bit int
	localparam logic [7:0]  SPAN_FAST_STEPS = 8'(T_SPAN_FAST_US * 1000 / (T_STEP_FAST_PS / 1000));
	localparam logic [7:0]  SPAN_SLOW_STEPS = 8'(T_SPAN_SLOW_US * 1000 / (T_STEP_SLOW_PS / 1000));
	// register byte offsets
	localparam logic [7:0]  REG_CONFIG  = 8'h00;
	localparam logic [7:0]  REG_REFRESH = 8'h04;
	localparam logic [7:0]  REG_KEY     = 8'h08;
	localparam logic [7:0]  REG_COMMAND = 8'h0C;
	localparam logic [7:0]  REG_STATUS  = 8'h10;
	localparam logic [7:0]  REG_SEED    = 8'h14;
	// config fields and reset values
	localparam int          CFG_SLOW_BIT = 0;
	localparam int          CFG_OPEN_LSB = 8;
	localparam int          CFG_LEN_LSB  = 16;
	localparam logic [7:0]  OPEN_RST     = 8'h40;
	localparam logic [7:0]  LEN_RST      = 8'h80;
	// command bits
	localparam int          CMD_DIAG    = 0;
	localparam int          CMD_TO_DIS  = 1;
	localparam int          CMD_TEST    = 2;
	localparam int          CMD_OVR     = 3;
	localparam int          CMD_RECOVER = 4;
	localparam int          CMD_FSM_RST = 5;
	localparam int          CMD_SSM_RST = 6;
	// refresh codes
	localparam logic [1:0]  CODE_A = 2'h1;
	localparam logic [1:0]  CODE_B = 2'h2;
	// window watchdog states
	typedef enum logic [2:0] {
		W1_INIT  = 3'h1,
		W1_RUN   = 3'h2,
		W1_RESET = 3'h4
	} dlwd_w1_t;
	// algorithmic watchdog states
	typedef enum logic [9:0] {
		W2_INIT     = 10'h001,
		W2_OVERRIDE = 10'h002,
		W2_SEEDINIT = 10'h004,
		W2_RUN      = 10'h008,
		W2_TEST     = 10'h010,
		W2_QUAL     = 10'h020,
		W2_LOCK     = 10'h040,
		W2_STOPPING = 10'h080,
		W2_STOP     = 10'h100,
		W2_RESET    = 10'h200
	} dlwd_w2_t;
endpackage

// file: verilog/dlwd_top.sv
// dual level watchdog with ahb-lite register slave
`timescale 1ns/100ps
module dlwd_top #(
	parameter int         STEP_SLOW_CYC = dlwd_pkg::STEP_SLOW_CYC,
	parameter int         MS_CYC        = dlwd_pkg::T_STATE_MS * dlwd_pkg::CYC_PER_MS,
	parameter int         INIT_CYC      = dlwd_pkg::T_INIT_MS * dlwd_pkg::CYC_PER_MS,
	parameter int         WD2_TMO_CYC   = 20000000,
	parameter logic [3:0] RETRY_MAX     = 4'h3,
	parameter logic [7:0] DEFAULT_KEY   = 8'h5A
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        watchdog_disable_pin,
	output logic             wd_reset_out,
	output logic             algorithmic_lock_flag,
	output logic             window_error
);
	logic              dis_meta;
	logic              dis;
	logic              dp_wr;
	logic [7:0]        dp_addr;
	logic              op_diag;
	logic              to_dis;
	logic              cfg_slow;
	logic [7:0]        open_steps;
	logic [7:0]        len_steps;
	logic [15:0]       step_cnt;
	logic              step_tick;
	logic [7:0]        w1_timer;
	logic [1:0]        half_code;
	logic [31:0]       init_cnt;
	logic [31:0]       w1_ms;
	logic              window_latch;
	dlwd_pkg::dlwd_w1_t w1_state;
	logic [31:0]       w2_cnt;
	logic [31:0]       w2_ms;
	logic [7:0]        seed_run;
	logic [7:0]        seed;
	logic [7:0]        prev_key;
	logic [7:0]        exp_key;
	logic [3:0]        retry_counter;
	logic              test_flag;
	logic              recovered;
	logic              algorithmic_reset_latch;
	dlwd_pkg::dlwd_w2_t w2_state;

	// returns value of a write bit in the command register
	function automatic logic cmd_bit(input logic [7:0] a, input logic w, input logic [31:0] d,
		input int b);
		cmd_bit = w && a == dlwd_pkg::REG_COMMAND && d[b];
	endfunction

	// ahb-lite: zero wait, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// disable pin synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dis_meta <= 1'b0;
			dis      <= 1'b0;
		end else begin
			dis_meta <= watchdog_disable_pin;
			dis      <= dis_meta;
		end
	end

	// address phase capture and registered read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr   <= 1'b0;
			dp_addr <= 8'h00;
			hrdata  <= 32'h0000_0000;
		end else if (hready) begin
			dp_wr   <= hsel && htrans[1] && hwrite;
			dp_addr <= haddr[7:0];
			if (hsel && htrans[1] && !hwrite) begin
				unique case (haddr[7:0])
					dlwd_pkg::REG_CONFIG:  hrdata <= {8'h00, len_steps, open_steps, 7'h00, cfg_slow};
					dlwd_pkg::REG_REFRESH: hrdata <= {24'h000000, w1_timer};
					dlwd_pkg::REG_STATUS:  hrdata <= {retry_counter, 2'h0, w2_state, 5'h00, w1_state,
						2'h0, to_dis, op_diag, dis, algorithmic_lock_flag,
						algorithmic_reset_latch, window_latch};
					dlwd_pkg::REG_SEED:    hrdata <= {16'h0000, prev_key, seed};
					default:               hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// write strobes in the data phase
	logic wr_cfg;
	logic wr_ref;
	logic wr_key;
	logic wr_stat;
	logic fsm_rst;
	logic ssm_rst;
	assign wr_cfg  = dp_wr && dp_addr == dlwd_pkg::REG_CONFIG;
	assign wr_ref  = dp_wr && dp_addr == dlwd_pkg::REG_REFRESH;
	assign wr_key  = dp_wr && dp_addr == dlwd_pkg::REG_KEY;
	assign wr_stat = dp_wr && dp_addr == dlwd_pkg::REG_STATUS;
	assign fsm_rst = cmd_bit(dp_addr, dp_wr, hwdata, dlwd_pkg::CMD_FSM_RST);
	assign ssm_rst = cmd_bit(dp_addr, dp_wr, hwdata, dlwd_pkg::CMD_SSM_RST);

	// operating state, timeout disable and frozen configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_diag    <= 1'b0;
			to_dis     <= 1'b0;
			cfg_slow   <= 1'b0;
			open_steps <= dlwd_pkg::OPEN_RST;
			len_steps  <= dlwd_pkg::LEN_RST;
		end else begin
			if (cmd_bit(dp_addr, dp_wr, hwdata, dlwd_pkg::CMD_DIAG))
				op_diag <= 1'b1;
			if (fsm_rst)
				to_dis <= 1'b0;
			else if (cmd_bit(dp_addr, dp_wr, hwdata, dlwd_pkg::CMD_TO_DIS))
				to_dis <= 1'b1;
			if (wr_cfg && !op_diag) begin
				cfg_slow   <= hwdata[dlwd_pkg::CFG_SLOW_BIT];
				open_steps <= hwdata[dlwd_pkg::CFG_OPEN_LSB +: 8];
				len_steps  <= hwdata[dlwd_pkg::CFG_LEN_LSB +: 8];
			end
		end
	end

	// step divider, 8 us or 64 us ticks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			step_cnt <= 16'h0000;
		else if (step_tick || dis)
			step_cnt <= 16'h0000;
		else
			step_cnt <= step_cnt + 16'h0001;
	end
	assign step_tick = step_cnt == 16'(cfg_slow ? STEP_SLOW_CYC - 1
		: dlwd_pkg::STEP_FAST_CYC - 1);

	// refresh code pairing and window decode
	logic       code_ok;
	logic       pair_done;
	logic [8:0] win_end;
	logic       in_window;
	logic [7:0] span_max;
	logic       w1_active;
	logic       w1_err;
	assign code_ok   = wr_ref && (hwdata[1:0] == dlwd_pkg::CODE_A
		|| hwdata[1:0] == dlwd_pkg::CODE_B);
	assign pair_done = code_ok && half_code != 2'h0 && hwdata[1:0] != half_code;
	assign win_end   = {1'b0, open_steps} + {1'b0, len_steps};
	assign in_window = w1_timer >= open_steps && {1'b0, w1_timer} < win_end;
	assign span_max  = cfg_slow ? dlwd_pkg::SPAN_SLOW_STEPS : dlwd_pkg::SPAN_FAST_STEPS;
	assign w1_active = op_diag && !dis;
	// early, late or missed initial service
	assign w1_err = w1_active && (
		(w1_state == dlwd_pkg::W1_RUN && pair_done && !in_window) ||
		(w1_state == dlwd_pkg::W1_RUN && ({1'b0, w1_timer} >= win_end || w1_timer == span_max)) ||
		(w1_state == dlwd_pkg::W1_INIT && !to_dis
			&& init_cnt == 32'(INIT_CYC - 1)));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			half_code <= 2'h0;
		else if (fsm_rst || pair_done)
			half_code <= 2'h0;
		else if (code_ok)
			half_code <= hwdata[1:0];
	end

	// window watchdog timer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			w1_timer <= 8'h00;
		else if (!w1_active || fsm_rst || w1_state != dlwd_pkg::W1_RUN || pair_done)
			w1_timer <= 8'h00;
		else if (step_tick && w1_timer != span_max)
			w1_timer <= w1_timer + 8'h01;
	end

	// initial allowance and reset duration counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_cnt <= 32'h0000_0000;
			w1_ms    <= 32'h0000_0000;
		end else begin
			if (w1_active && w1_state == dlwd_pkg::W1_INIT && !to_dis && !w1_err)
				init_cnt <= init_cnt + 32'h0000_0001;
			else
				init_cnt <= 32'h0000_0000;
			if (w1_state == dlwd_pkg::W1_RESET)
				w1_ms <= w1_ms + 32'h0000_0001;
			else
				w1_ms <= 32'h0000_0000;
		end
	end

	// window watchdog state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			w1_state <= dlwd_pkg::W1_INIT;
		else if (fsm_rst)
			w1_state <= dlwd_pkg::W1_INIT;
		else begin
			unique case (w1_state)
				dlwd_pkg::W1_INIT: begin
					if (w1_err)
						w1_state <= dlwd_pkg::W1_RESET;
					else if (w1_active && pair_done)
						w1_state <= dlwd_pkg::W1_RUN;
				end
				dlwd_pkg::W1_RUN: begin
					if (w1_err)
						w1_state <= dlwd_pkg::W1_RESET;
				end
				dlwd_pkg::W1_RESET: begin
					if (w1_ms == 32'(MS_CYC - 1))
						w1_state <= dlwd_pkg::W1_INIT;
				end
			endcase
		end
	end

	// window error pulse and sticky status, set beats clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			window_error <= 1'b0;
			window_latch <= 1'b0;
		end else begin
			window_error <= w1_err;
			if (w1_err)
				window_latch <= 1'b1;
			else if (fsm_rst || (wr_stat && hwdata[0]))
				window_latch <= 1'b0;
		end
	end

	// algorithmic watchdog decode
	logic key_ok;
	logic w2_timing;
	logic w2_exp;
	logic w2_ms_done;
	assign key_ok     = wr_key && hwdata[7:0] == (w2_state == dlwd_pkg::W2_INIT
		? DEFAULT_KEY : exp_key);
	assign w2_timing  = !dis && (w2_state == dlwd_pkg::W2_SEEDINIT || w2_state == dlwd_pkg::W2_RUN
		|| w2_state == dlwd_pkg::W2_QUAL || w2_state == dlwd_pkg::W2_TEST);
	assign w2_exp     = w2_timing && w2_cnt == 32'(WD2_TMO_CYC - 1);
	assign w2_ms_done = w2_ms == 32'(MS_CYC - 1);

	// seed counter, seed latch and key chain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seed_run <= 8'h00;
			seed     <= 8'h00;
			prev_key <= 8'h00;
			exp_key  <= 8'h00;
		end else begin
			seed_run <= seed_run + 8'h01;
			if (fsm_rst) begin
				seed     <= 8'h00;
				prev_key <= 8'h00;
				exp_key  <= 8'h00;
			end else if (key_ok && w2_state != dlwd_pkg::W2_STOP
				&& w2_state != dlwd_pkg::W2_OVERRIDE) begin
				seed     <= seed_run;
				prev_key <= hwdata[7:0];
				exp_key  <= (seed_run ^ hwdata[7:0]) + 8'h01;
			end
		end
	end

	// maximum time and state duration counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			w2_cnt <= 32'h0000_0000;
			w2_ms  <= 32'h0000_0000;
		end else begin
			if (!w2_timing || key_ok || w2_exp || fsm_rst)
				w2_cnt <= 32'h0000_0000;
			else
				w2_cnt <= w2_cnt + 32'h0000_0001;
			if ((w2_state == dlwd_pkg::W2_RESET || w2_state == dlwd_pkg::W2_STOPPING) && !w2_ms_done)
				w2_ms <= w2_ms + 32'h0000_0001;
			else
				w2_ms <= 32'h0000_0000;
		end
	end

	// algorithmic watchdog state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			w2_state <= dlwd_pkg::W2_INIT;
		else if (fsm_rst)
			w2_state <= dlwd_pkg::W2_INIT;
		else if (ssm_rst && w2_state != dlwd_pkg::W2_STOP)
			w2_state <= dlwd_pkg::W2_INIT;
		else begin
			unique case (w2_state)
				dlwd_pkg::W2_INIT: begin
					if (cmd_bit(dp_addr, dp_wr, hwdata, dlwd_pkg::CMD_OVR))
						w2_state <= dlwd_pkg::W2_OVERRIDE;
					else if (key_ok)
						w2_state <= dlwd_pkg::W2_SEEDINIT;
				end
				dlwd_pkg::W2_OVERRIDE: w2_state <= dlwd_pkg::W2_OVERRIDE;
				dlwd_pkg::W2_SEEDINIT, dlwd_pkg::W2_RUN: begin
					if (key_ok)
						w2_state <= dlwd_pkg::W2_RUN;
					else if (w2_exp)
						w2_state <= dlwd_pkg::W2_QUAL;
					else if (w2_state == dlwd_pkg::W2_RUN
						&& cmd_bit(dp_addr, dp_wr, hwdata, dlwd_pkg::CMD_TEST))
						w2_state <= dlwd_pkg::W2_TEST;
				end
				dlwd_pkg::W2_QUAL: begin
					if (key_ok)
						w2_state <= dlwd_pkg::W2_RUN;
					else if (w2_exp && retry_counter + 4'h1 >= RETRY_MAX)
						w2_state <= dlwd_pkg::W2_RESET;
				end
				dlwd_pkg::W2_TEST: begin
					if (key_ok)
						w2_state <= dlwd_pkg::W2_RUN;
					else if (w2_exp)
						w2_state <= dlwd_pkg::W2_RESET;
				end
				dlwd_pkg::W2_RESET: begin
					if (w2_ms_done)
						w2_state <= test_flag ? dlwd_pkg::W2_RUN : dlwd_pkg::W2_LOCK;
				end
				dlwd_pkg::W2_LOCK: begin
					if (key_ok)
						w2_state <= recovered ? dlwd_pkg::W2_STOPPING : dlwd_pkg::W2_RUN;
				end
				dlwd_pkg::W2_STOPPING: begin
					if (w2_ms_done)
						w2_state <= dlwd_pkg::W2_STOP;
				end
				dlwd_pkg::W2_STOP: w2_state <= dlwd_pkg::W2_STOP;
			endcase
		end
	end

	// retry counter, test marker, recovery memory
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			retry_counter <= 4'h0;
			test_flag     <= 1'b0;
			recovered     <= 1'b0;
		end else if (fsm_rst) begin
			retry_counter <= 4'h0;
			test_flag     <= 1'b0;
			recovered     <= 1'b0;
		end else begin
			if (w2_exp && (w2_state == dlwd_pkg::W2_QUAL || w2_state == dlwd_pkg::W2_RUN
				|| w2_state == dlwd_pkg::W2_SEEDINIT))
				retry_counter <= retry_counter + 4'h1;
			else if (cmd_bit(dp_addr, dp_wr, hwdata, dlwd_pkg::CMD_RECOVER))
				retry_counter <= 4'h0;
			if (w2_state == dlwd_pkg::W2_TEST)
				test_flag <= 1'b1;
			else if (w2_state != dlwd_pkg::W2_RESET)
				test_flag <= 1'b0;
			if (w2_state == dlwd_pkg::W2_LOCK && key_ok)
				recovered <= 1'b1;
		end
	end

	// lock flag and reset latch; lock flag is raised at startup
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			algorithmic_lock_flag   <= 1'b1;
			algorithmic_reset_latch <= 1'b0;
			wd_reset_out            <= 1'b0;
		end else begin
			if (fsm_rst)
				algorithmic_lock_flag <= 1'b0;
			else if (w2_state == dlwd_pkg::W2_RESET && !test_flag)
				algorithmic_lock_flag <= 1'b1;
			if (fsm_rst)
				algorithmic_reset_latch <= 1'b0; // fsm reset outranks a set
			else if (w2_state == dlwd_pkg::W2_RESET)
				algorithmic_reset_latch <= 1'b1;
			wd_reset_out <= w1_state == dlwd_pkg::W1_RESET
				|| (w2_state == dlwd_pkg::W2_RESET && !test_flag);
		end
	end

	// checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_cfg_frozen: assert property (op_diag |=> $stable(open_steps) && $stable(cfg_slow))
		else $error("config changed after diag");
	chk_diag_sticky: assert property (op_diag |=> op_diag)
		else $error("diag state left");
	chk_bad_code_quiet: assert property (wr_ref && !code_ok && half_code == 2'h0
		&& w1_state == dlwd_pkg::W1_RUN && {1'b0, w1_timer} < win_end && w1_timer != span_max
		|-> !w1_err) else $error("wrong code raised error");
	chk_early_error: assert property (w1_active && w1_state == dlwd_pkg::W1_RUN
		&& pair_done && w1_timer < open_steps |=> window_error && w1_state == dlwd_pkg::W1_RESET)
		else $error("early refresh not flagged");
	chk_window_restart: assert property (w1_active && w1_state == dlwd_pkg::W1_RUN
		&& pair_done && in_window && w1_timer != span_max && !fsm_rst
		|=> w1_timer == 8'h00 && w1_state == dlwd_pkg::W1_RUN)
		else $error("in-window refresh not accepted");
	chk_disable_hold: assert property (dis |=> w1_timer == 8'h00 && !window_error)
		else $error("timer ran while disabled");
	chk_test_no_reset: assert property (w2_state == dlwd_pkg::W2_TEST
		##1 w2_state == dlwd_pkg::W2_RESET |-> ##1 (!wd_reset_out
		|| $past(w1_state) == dlwd_pkg::W1_RESET) && algorithmic_reset_latch)
		else $error("test drove reset");
	chk_stop_sticky: assert property (w2_state == dlwd_pkg::W2_STOP && !fsm_rst
		|=> w2_state == dlwd_pkg::W2_STOP) else $error("stop state left");
	chk_fsm_reset: assert property (fsm_rst |=> w2_state == dlwd_pkg::W2_INIT
		&& w1_state == dlwd_pkg::W1_INIT && !algorithmic_reset_latch)
		else $error("fsm reset incomplete");
	chk_retry_count: assert property (w2_exp && w2_state == dlwd_pkg::W2_QUAL && !fsm_rst
		|=> retry_counter == $past(retry_counter) + 4'h1) else $error("retry not counted");
	chk_key_chain: assert property (key_ok && w2_state == dlwd_pkg::W2_RUN && !fsm_rst
		|=> exp_key == (seed ^ prev_key) + 8'h01) else $error("key chain wrong");

	cov_window_refresh: cover property (w1_state == dlwd_pkg::W1_RUN && pair_done && in_window);
	cov_qual_to_reset: cover property (w2_state == dlwd_pkg::W2_QUAL
		##1 w2_state == dlwd_pkg::W2_RESET);
	cov_reach_stop: cover property (w2_state == dlwd_pkg::W2_STOP);
	cov_w2_test: cover property (w2_state == dlwd_pkg::W2_TEST);
endmodule
